/* File: common/dsmsel_cfg.svh */
// Constants of the modulator source and high carrier selection block.
// Assumes inclusion by bare name from any file that needs them.
`ifndef DSMSEL_CFG_SVH
`define DSMSEL_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DSMSEL_OFS_SRC    4'h0
`define DSMSEL_OFS_CARH   4'h1
`define DSMSEL_OFS_CTRL   4'h2
`define DSMSEL_OFS_STAT   4'h3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DSMSEL_ODIS_BIT   7
`define DSMSEL_POL_BIT    6
`define DSMSEL_SYNC_BIT   5
`define DSMSEL_SEL_MSB    3
`define DSMSEL_SEL_LSB    0
`define DSMSEL_EN_BIT     7
`define DSMSEL_PBIT_BIT   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSMSEL_SRC_RST    8'h00
`define DSMSEL_CARH_RST   8'h00
`define DSMSEL_CTRL_RST   8'h00
`define DSMSEL_READ_NONE  8'h00

// ----------------------------------------------------------------
// Modulation source codes
// ----------------------------------------------------------------
`define DSMSEL_MS_PBIT    4'h0
`define DSMSEL_MS_PIN     4'h1
`define DSMSEL_MS_CCP     4'h2
`define DSMSEL_MS_CMP1    4'h6
`define DSMSEL_MS_CMP2    4'h7
`define DSMSEL_MS_SPI     4'h8
`define DSMSEL_MS_UART    4'hA

// ----------------------------------------------------------------
// High carrier codes
// ----------------------------------------------------------------
`define DSMSEL_CH_GND     4'h0
`define DSMSEL_CH_PIN1    4'h1
`define DSMSEL_CH_PIN2    4'h2
`define DSMSEL_CH_REFCLK  4'h3
`define DSMSEL_CH_CCP     4'h4

`endif

/* File: common/dsmsel_pkg.sv */
// Types shared by the modulator source and high carrier selection block.
// Assumes the constants header is compiled alongside.
package dsmsel_pkg;

  // Register bus request, one cycle per strobe
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dsmsel_bus_t;

  // Modulation source register layout
  typedef struct packed {
    logic       mod_source_pin_drive_off;
    logic [2:0] unused;
    logic [3:0] mod_source_select;
  } dsmsel_src_t;

  // High carrier register layout
  typedef struct packed {
    logic       hi_carrier_pin_drive_off;
    logic       hi_carrier_invert;
    logic       hi_carrier_edge_sync;
    logic       unused;
    logic [3:0] hi_carrier_select;
  } dsmsel_carh_t;

  // On-chip peripheral outputs on the core clock, also used for pin drive control
  typedef struct packed {
    logic capture_compare_pwm_out;
    logic spi_serial_data_out;
    logic uart_tx;
    logic cmp1_out;
    logic cmp2_out;
    logic reference_clock_out;
  } dsmsel_periph_t;

  // Carrier in use by the mixer
  typedef enum logic [2:0] {
    ST_LOW  = 3'b001,
    ST_HIGH = 3'b010,
    ST_WAIT = 3'b100
  } dsmsel_state_t;

endpackage

/* File: design/dsmsel_mod_mux.sv */
// Modulation source multiplexer.
// Assumes all inputs are already on the core clock.
`timescale 1ns/100ps
`include "dsmsel_cfg.svh"
module dsmsel_mod_mux #(
  parameter bit HAS_CMP2 = 1'b1              // Larger variant has comparator 2
) (
  input  wire logic                 [3:0] select,    // Effective source code
  input  wire logic                       prog_bit,  // Programmable bit
  input  wire logic                       pin,       // Synchronised input pin
  input  wire logic                       pwm_mode,  // Capture unit is in PWM mode
  input  wire dsmsel_pkg::dsmsel_periph_t per,       // Peripheral outputs
  output logic                            mod_raw    // Selected modulator
);
  import dsmsel_pkg::*;

  // Reserved codes give a steady low so nothing floats into the mixer
  always_comb begin
    case (select)
      `DSMSEL_MS_PBIT: mod_raw = prog_bit;
      `DSMSEL_MS_PIN:  mod_raw = pin;
      `DSMSEL_MS_CCP:  mod_raw = pwm_mode & per.capture_compare_pwm_out;
      `DSMSEL_MS_CMP1: mod_raw = per.cmp1_out;
      `DSMSEL_MS_CMP2: mod_raw = HAS_CMP2 & per.cmp2_out;
      `DSMSEL_MS_SPI:  mod_raw = per.spi_serial_data_out;
      `DSMSEL_MS_UART: mod_raw = per.uart_tx;
      default:         mod_raw = 1'b0;
    endcase
  end
endmodule

/* File: design/dsmsel_car_mux.sv */
// High carrier multiplexer.
// Assumes all inputs are already on the core clock.
`timescale 1ns/100ps
`include "dsmsel_cfg.svh"
module dsmsel_car_mux (
  input  wire logic                 [3:0] select,    // Effective carrier code
  input  wire logic                       pin1,      // Synchronised carrier pin 1
  input  wire logic                       pin2,      // Synchronised carrier pin 2
  input  wire logic                       pwm_mode,  // Capture unit is in PWM mode
  input  wire dsmsel_pkg::dsmsel_periph_t per,       // Peripheral outputs
  output logic                            car_raw    // Selected carrier
);
  import dsmsel_pkg::*;

  // Ground and reserved codes both give low
  always_comb begin
    case (select)
      `DSMSEL_CH_PIN1:   car_raw = pin1;
      `DSMSEL_CH_PIN2:   car_raw = pin2;
      `DSMSEL_CH_REFCLK: car_raw = per.reference_clock_out;
      `DSMSEL_CH_CCP:    car_raw = pwm_mode & per.capture_compare_pwm_out;
      default:           car_raw = 1'b0;
    endcase
  end
endmodule

/* File: design/dsmsel_top.sv */
// Modulator source and high carrier selection with carrier switching.
// Assumes pins and comparators are asynchronous; other inputs share mclk.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "dsmsel_cfg.svh"
module dsmsel_top #(
  parameter bit HAS_CMP2 = 1'b1                      // Larger variant has comparator 2
) (
  input  wire logic                       mclk,          // Core clock
  input  wire logic                       rst_n,         // Power-on reset, async
  input  wire logic                       ce,            // Clock enable, freezes all
  input  wire logic                       soft_reset,    // Other device reset, sync
  input  wire dsmsel_pkg::dsmsel_bus_t    bus,           // Register request
  output logic                      [7:0] rdata,         // Read data, cycle after rd
  input  wire logic                       mod_input_pin, // Modulator input pin
  input  wire logic                       carrier_input_pin_1, // Carrier pin 1
  input  wire logic                       carrier_input_pin_2, // Carrier pin 2
  input  wire logic                       cmp1_async,    // Comparator 1 output
  input  wire logic                       cmp2_async,    // Comparator 2 output
  input  wire dsmsel_pkg::dsmsel_periph_t per,           // Same-clock peripherals
  input  wire logic                       pwm_mode,      // Capture unit in PWM mode
  input  wire logic                       carrier_low,   // Selected low carrier
  output logic                            mod_signal,    // Selected modulator
  output logic                            hi_carrier,    // Selected high carrier
  output logic                            mod_out,       // Mixed carrier stream
  output dsmsel_pkg::dsmsel_periph_t      pin_drive_off  // Per peripheral pin release
);
  import dsmsel_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int NSYNC = 5;
  dsmsel_src_t        src_reg;
  dsmsel_carh_t       carh_reg;
  logic               module_enable_bit;
  logic               programmable_mod_bit;
  logic [NSYNC-1:0]   async_in;
  logic [NSYNC-1:0]   sync_meta;
  logic [NSYNC-1:0]   sync_q;
  dsmsel_periph_t     per_eff;
  logic [3:0]         src_sel_eff;
  logic [3:0]         carh_sel_eff;
  logic               mod_raw;
  logic               car_raw;
  logic               lo_q;
  logic               hi_prev;
  logic               hi_fall;
  dsmsel_state_t      state;
  dsmsel_state_t      next_state;

  // Select hit gated by the pin release bit and the module enable
  function automatic logic off_hit(input logic en, input logic odis,
                                   input logic [3:0] sel, input logic [3:0] code);
    off_hit = en & odis & (sel == code);
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  assign async_in = {cmp2_async, cmp1_async, carrier_input_pin_2,
                     carrier_input_pin_1, mod_input_pin};

  // Two stages per line; only the second stage is read downstream
  generate
    for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          sync_meta[gi] <= 1'b0;
          sync_q[gi]    <= 1'b0;
        end else if (ce) begin
          sync_meta[gi] <= async_in[gi];
          sync_q[gi]    <= sync_meta[gi];
        end
      end
    end
  endgenerate

  // Comparators arrive unsynchronised, so take their cleaned copies
  always_comb begin
    per_eff          = per;
    per_eff.cmp1_out = sync_q[3];
    per_eff.cmp2_out = sync_q[4];
  end

  // ----------------------------------------------------------------
  // Select registers
  // ----------------------------------------------------------------
  // Only power-on reset clears them; the other reset leaves them intact
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_reg  <= `DSMSEL_SRC_RST;
      carh_reg <= `DSMSEL_CARH_RST;
    end else if (ce && bus.wr) begin
      if (bus.addr == `DSMSEL_OFS_SRC) begin
        src_reg.mod_source_pin_drive_off <= bus.wdata[`DSMSEL_ODIS_BIT];
        src_reg.mod_source_select <= bus.wdata[`DSMSEL_SEL_MSB:`DSMSEL_SEL_LSB];
      end
      if (bus.addr == `DSMSEL_OFS_CARH) begin
        carh_reg.hi_carrier_pin_drive_off <= bus.wdata[`DSMSEL_ODIS_BIT];
        carh_reg.hi_carrier_invert        <= bus.wdata[`DSMSEL_POL_BIT];
        carh_reg.hi_carrier_edge_sync     <= bus.wdata[`DSMSEL_SYNC_BIT];
        carh_reg.hi_carrier_select <= bus.wdata[`DSMSEL_SEL_MSB:`DSMSEL_SEL_LSB];
      end
    end
  end

  // Control register: any reset disables the module
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      module_enable_bit    <= 1'b0;
      programmable_mod_bit <= 1'b0;
    end else if (ce) begin
      if (soft_reset) begin
        module_enable_bit    <= 1'b0;
        programmable_mod_bit <= 1'b0;
      end else if (bus.wr && bus.addr == `DSMSEL_OFS_CTRL) begin
        module_enable_bit    <= bus.wdata[`DSMSEL_EN_BIT];
        programmable_mod_bit <= bus.wdata[`DSMSEL_PBIT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unused field bits were never stored, so they read back as zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `DSMSEL_READ_NONE;
    end else if (ce) begin
      if (!bus.rd) begin
        rdata <= `DSMSEL_READ_NONE;
      end else begin
        case (bus.addr)
          `DSMSEL_OFS_SRC:  rdata <= {src_reg.mod_source_pin_drive_off, 3'h0,
                                      src_reg.mod_source_select};
          `DSMSEL_OFS_CARH: rdata <= {carh_reg.hi_carrier_pin_drive_off,
                                      carh_reg.hi_carrier_invert,
                                      carh_reg.hi_carrier_edge_sync, 1'b0,
                                      carh_reg.hi_carrier_select};
          `DSMSEL_OFS_CTRL: rdata <= {module_enable_bit, 6'h00, programmable_mod_bit};
          `DSMSEL_OFS_STAT: rdata <= {3'h0, state == ST_WAIT, mod_out,
                                      state != ST_LOW, hi_carrier, mod_signal};
          default:          rdata <= `DSMSEL_READ_NONE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  // Disabled module falls back to the programmable bit and to ground,
  // while the stored selections stay untouched for re-enabling
  assign src_sel_eff  = module_enable_bit ? src_reg.mod_source_select
                                          : `DSMSEL_MS_PBIT;
  assign carh_sel_eff = module_enable_bit ? carh_reg.hi_carrier_select
                                          : `DSMSEL_CH_GND;

  dsmsel_mod_mux #(
    .HAS_CMP2 (HAS_CMP2)
  ) u_mod_mux (
    .select   (src_sel_eff),
    .prog_bit (programmable_mod_bit),
    .pin      (sync_q[0]),
    .pwm_mode (pwm_mode),
    .per      (per_eff),
    .mod_raw  (mod_raw)
  );

  dsmsel_car_mux u_car_mux (
    .select   (carh_sel_eff),
    .pin1     (sync_q[1]),
    .pin2     (sync_q[2]),
    .pwm_mode (pwm_mode),
    .per      (per_eff),
    .car_raw  (car_raw)
  );

  // Selected signals are registered so the mixer sees aligned inputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mod_signal <= 1'b0;
      hi_carrier <= 1'b0;
      lo_q       <= 1'b0;
      hi_prev    <= 1'b0;
    end else if (ce) begin
      mod_signal <= mod_raw;
      hi_carrier <= module_enable_bit & (car_raw ^ carh_reg.hi_carrier_invert);
      lo_q       <= module_enable_bit & carrier_low;
      hi_prev    <= hi_carrier;
    end
  end

  // ----------------------------------------------------------------
  // Carrier switching
  // ----------------------------------------------------------------
  assign hi_fall = hi_prev & ~hi_carrier;

  // The wait state lets the running high pulse finish instead of clipping it
  always_comb begin
    case (state)
      ST_LOW: begin
        next_state = mod_signal ? ST_HIGH : ST_LOW;
      end
      ST_HIGH: begin
        if (mod_signal) begin
          next_state = ST_HIGH;
        end else if (carh_reg.hi_carrier_edge_sync) begin
          next_state = ST_WAIT;
        end else begin
          next_state = ST_LOW;
        end
      end
      ST_WAIT: begin
        if (mod_signal) begin
          next_state = ST_HIGH;
        end else if (hi_fall || !carh_reg.hi_carrier_edge_sync) begin
          next_state = ST_LOW;
        end else begin
          next_state = ST_WAIT;
        end
      end
      default: begin
        next_state = ST_LOW;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_LOW;
    end else if (ce) begin
      state <= soft_reset ? ST_LOW : next_state;
    end
  end

  // Mixer output follows the carrier chosen for the next cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mod_out <= 1'b0;
    end else if (ce) begin
      mod_out <= (next_state == ST_LOW) ? lo_q : hi_carrier;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral pin drive release
  // ----------------------------------------------------------------
  // A peripheral keeps its pin unless it is the selected source or high carrier and released
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_drive_off <= '0;
    end else if (ce) begin
      pin_drive_off.capture_compare_pwm_out <=
        off_hit(module_enable_bit, src_reg.mod_source_pin_drive_off,
                src_reg.mod_source_select, `DSMSEL_MS_CCP) |
        off_hit(module_enable_bit, carh_reg.hi_carrier_pin_drive_off,
                carh_reg.hi_carrier_select, `DSMSEL_CH_CCP);
      pin_drive_off.spi_serial_data_out <= off_hit(module_enable_bit,
        src_reg.mod_source_pin_drive_off, src_reg.mod_source_select, `DSMSEL_MS_SPI);
      pin_drive_off.uart_tx <= off_hit(module_enable_bit,
        src_reg.mod_source_pin_drive_off, src_reg.mod_source_select, `DSMSEL_MS_UART);
      pin_drive_off.cmp1_out <= off_hit(module_enable_bit,
        src_reg.mod_source_pin_drive_off, src_reg.mod_source_select, `DSMSEL_MS_CMP1);
      pin_drive_off.cmp2_out <= HAS_CMP2 & off_hit(module_enable_bit,
        src_reg.mod_source_pin_drive_off, src_reg.mod_source_select, `DSMSEL_MS_CMP2);
      pin_drive_off.reference_clock_out <= off_hit(module_enable_bit,
        carh_reg.hi_carrier_pin_drive_off, carh_reg.hi_carrier_select,
        `DSMSEL_CH_REFCLK);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_src_pin_off: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && module_enable_bit && src_reg.mod_source_select == `DSMSEL_MS_UART)
    |=> (pin_drive_off.uart_tx == $past(src_reg.mod_source_pin_drive_off)))
    else $error("uart pin release does not follow source disable bit");

  a_src_read_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && bus.rd && bus.addr == `DSMSEL_OFS_SRC)
    |=> (rdata[6:4] == 3'h0 && rdata[3:0] == $past(src_reg.mod_source_select)))
    else $error("source read data wrong");

  a_mod_pin_route: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && module_enable_bit && src_reg.mod_source_select == `DSMSEL_MS_PIN)
    |=> (mod_signal == $past(sync_q[0])))
    else $error("modulator does not follow input pin");

  a_mod_spi_route: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && module_enable_bit && src_reg.mod_source_select == `DSMSEL_MS_SPI)
    |=> (mod_signal == $past(per.spi_serial_data_out)))
    else $error("modulator does not follow spi data");

  a_mod_rsvd_low: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && module_enable_bit && src_reg.mod_source_select inside {4'h3, 4'h4, 4'h5,
      4'h9, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF}) |=> !mod_signal)
    else $error("reserved source code drives modulator");

  a_carh_invert: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && module_enable_bit && carh_reg.hi_carrier_select == `DSMSEL_CH_PIN1)
    |=> (hi_carrier == ($past(sync_q[1]) ^ $past(carh_reg.hi_carrier_invert))))
    else $error("high carrier polarity wrong");

  a_sync_wait: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && !soft_reset && state == ST_HIGH && !mod_signal &&
     carh_reg.hi_carrier_edge_sync) |=> (state == ST_WAIT))
    else $error("synchronised switch did not wait");

  a_nosync_switch: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && state == ST_HIGH && !mod_signal && !carh_reg.hi_carrier_edge_sync)
    |=> (state == ST_LOW))
    else $error("unsynchronised switch delayed");

  a_refclk_route: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && module_enable_bit && carh_reg.hi_carrier_select == `DSMSEL_CH_REFCLK &&
     !carh_reg.hi_carrier_invert) |=> (hi_carrier == $past(per.reference_clock_out)))
    else $error("high carrier does not follow reference clock");

  a_regs_hold: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (soft_reset && !bus.wr) |=> (src_reg == $past(src_reg) && carh_reg == $past(carh_reg)))
    else $error("select registers changed on soft reset");

  a_low_mix: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && !soft_reset && state == ST_LOW && !mod_signal) |=> (mod_out == $past(lo_q)))
    else $error("low carrier not mixed while modulator low");

  a_disabled_gnd: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (ce && !module_enable_bit)
    |=> (!hi_carrier && !lo_q && mod_signal == $past(programmable_mod_bit)))
    else $error("disabled module not forced to ground");

endmodule

/* File: verification/dsmsel_src_model.sv */
// Far-side model: peripherals, pins and low carrier feeding the selector.
// Assumes the bench sets three level bits; all outputs change after mclk.
`timescale 1ns/100ps
module dsmsel_src_model (
  input  wire logic                  mclk,   // Core clock
  input  wire logic            [2:0] lvl,    // 0 modulator, 1 carrier, 2 low carrier
  output dsmsel_pkg::dsmsel_periph_t per,    // Same-clock peripherals
  output logic                       pin_m,  // Modulator pin
  output logic                       pin_c1, // Carrier pin 1
  output logic                       pin_c2, // Carrier pin 2
  output logic                       cmp1,   // Comparator 1
  output logic                       cmp2,   // Comparator 2
  output logic                       lo      // Low carrier
);
  import dsmsel_pkg::*;
  // Unused struct comparator copies carry the inverse so a wrong tap shows
  always_ff @(posedge mclk) begin
    per    <= '{lvl[0], lvl[0], lvl[0], ~lvl[0], ~lvl[0], lvl[1]};
    pin_m  <= lvl[0];
    pin_c1 <= lvl[1];
    pin_c2 <= lvl[1];
    cmp1   <= lvl[0];
    cmp2   <= lvl[0];
    lo     <= lvl[2];
  end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the modulator source and high carrier selector.
// Assumes the far-side model and the design package are compiled first.
`timescale 1ns/100ps
module tb_top;
  import dsmsel_pkg::*;
  logic mclk = 0, rst_n = 0, pwm_mode = 1, soft_rst = 0;
  logic [2:0] lvl = 3'b000;
  dsmsel_bus_t bus = '0;
  dsmsel_periph_t per, pdo;
  logic [7:0] rdata;
  logic pin_m, pin_c1, pin_c2, cmp1, cmp2, lo, mod_signal, hi_carrier, mod_out;
  int fails = 0, samples_checked = 0;
  // ----------------------------------------
  // Clock, parts
  // ----------------------------------------
  initial forever #2.5 mclk = ~mclk;
  dsmsel_src_model u_dsmsel_src_model (.mclk(mclk), .lvl(lvl), .per(per), .pin_m(pin_m),
    .pin_c1(pin_c1), .pin_c2(pin_c2), .cmp1(cmp1), .cmp2(cmp2), .lo(lo));
  dsmsel_top u_dsmsel_top (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .soft_reset(soft_rst),
    .bus(bus), .rdata(rdata), .mod_input_pin(pin_m), .carrier_input_pin_1(pin_c1),
    .carrier_input_pin_2(pin_c2), .cmp1_async(cmp1), .cmp2_async(cmp2), .per(per),
    .pwm_mode(pwm_mode), .carrier_low(lo), .mod_signal(mod_signal),
    .hi_carrier(hi_carrier), .mod_out(mod_out), .pin_drive_off(pdo));
  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus.wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Levels need sync stages plus mixer register to settle
  task settle;
    repeat (6) @(posedge mclk);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    wr(4'h0, 8'hFF);
    wr(4'h1, 8'hFF);
    rd(4'h0, 8'h8F);
    rd(4'h1, 8'hEF);
    rd(4'h5, 8'h00);
    $display("regs done");
  endtask
  task t_src;
    wr(4'h1, 8'h00);
    for (int v = 0; v < 2; v++) for (int c = 0; c < 16; c++) begin
      lvl <= {2'b00, v[0]};
      wr(4'h2, {7'h40, v[0]});
      wr(4'h0, {4'h0, c[3:0]});
      settle();
      chk(mod_signal, v[0] & (c inside {0, 1, 2, 6, 7, 8, 10}));
    end
    $display("source table done");
  endtask
  task t_car;
    for (int v = 0; v < 2; v++) for (int c = 0; c < 16; c++) begin
      // PWM output follows level bit 0, so drive it with the carrier level too
      lvl <= {1'b0, v[0], v[0]};
      wr(4'h1, {4'h0, c[3:0]});
      settle();
      chk(hi_carrier, v[0] & (c inside {[1:4]}));
    end
    wr(4'h1, 8'h41);
    settle();
    chk(hi_carrier, 8'h00);
    $display("carrier table done");
  endtask
  task t_pins;
    wr(4'h0, 8'h8A);
    wr(4'h1, 8'h83);
    settle();
    chk({2'b00, pdo}, 8'h09);
    wr(4'h0, 8'h0A);
    settle();
    chk({2'b00, pdo}, 8'h01);
    $display("pin release done");
  endtask
  task t_mix;
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h01);
    lvl <= 3'b010;
    wr(4'h2, 8'h81);
    settle();
    chk(mod_out, 8'h01);
    wr(4'h2, 8'h80);
    settle();
    chk(mod_out, 8'h00);
    wr(4'h1, 8'h21);
    wr(4'h2, 8'h81);
    settle();
    wr(4'h2, 8'h80);
    settle();
    chk(mod_out, 8'h01);
    lvl <= 3'b100;
    settle();
    chk(mod_out, 8'h01);
    $display("mixing done");
  endtask
  task t_off;
    lvl <= 3'b010;
    wr(4'h1, 8'h01);
    wr(4'h2, 8'h01);
    settle();
    chk(hi_carrier, 8'h00);
    chk(mod_signal, 8'h01);
    rd(4'h1, 8'h01);
    // Other reset clears control and the switching state; selections must survive it
    @(posedge mclk) soft_rst <= 1'b1;
    @(posedge mclk) soft_rst <= 1'b0;
    rd(4'h2, 8'h00);
    rd(4'h1, 8'h01);
    $display("disable done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence, reset released on a clock edge
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_src();
    t_car();
    t_pins();
    t_mix();
    t_off();
    end_of_test();
  end
endmodule
